/* pkg/dpm_defines.vh */
// constants for the dual-port memory host port controller
`ifndef DPM_DEFINES_VH
`define DPM_DEFINES_VH

// array geometry of the largest variant
`define DPM_AW 14
`define DPM_DW 18
`define DPM_LO_MSB 8
`define DPM_HI_LSB 9

// mailbox words: highest word for the right port, next for the left port
`define DPM_MBX_RIGHT 14'h3FFF
`define DPM_MBX_LEFT 14'h3FFE

// token latch address lives in the low three address bits
`define DPM_TOK_AW 3

// user command codes
`define DPM_OP_MEM_RD 2'h0
`define DPM_OP_MEM_WR 2'h1
`define DPM_OP_TOK_RD 2'h2
`define DPM_OP_TOK_WR 2'h3

// role strap level for the lead role
`define DPM_ROLE_LEAD 1'h1

// clock period and pin timing in ns
`define DPM_CLK_NS 50
`define DPM_SELECT_TO_DATA_NS 25
`define DPM_OE_TO_DATA_NS 15
`define DPM_FLOW_THROUGH_NS 35
`define DPM_WRITE_PULSE_NS 20
`define DPM_TOKEN_RECOVER_NS 15

// least times round up to whole clock cycles
`define DPM_CEIL_CYC(ns) (((ns) + `DPM_CLK_NS - 1) / `DPM_CLK_NS)

// stages of the pin synchroniser, added to every read wait
`define DPM_SYNC_CYC 2

// longest wait on an active collision flag, in cycles
`define DPM_BUSY_TIMEOUT_CYC 8'h40

`endif

/* hw/dpm_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dpm_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // asynchronous pin level in, synchronised level out
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_q;

  // the first stage feeds only the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* hw/dpm_host.v */
// host controller driving one port of a dual-port memory through its pins
`timescale 1ns/10ps
`include "dpm_defines.vh"

// Functional notes
// - write ends on rising strobe edge; data held over that edge.
// - reads wait the flow-through delay before sampling data.
// - memory read asserts chip select and output enable, waits longest delay.
// - token read uses token select instead of chip select, plus output enable.
module dpm_host #(
  parameter RIGHT_PORT = 0
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // user command
  input wire cmd_valid,
  output reg cmd_ready_q,
  input wire [1:0] cmd_op,
  input wire [`DPM_AW-1:0] cmd_addr,
  input wire [`DPM_DW-1:0] cmd_wdata,
  input wire [1:0] cmd_lanes,
  // user answer
  output reg resp_valid_q,
  output reg [`DPM_DW-1:0] resp_rdata_q,
  output reg resp_collided_q,
  // user status
  output reg mail_pending_q,
  output reg busy_now_q,
  // memory port pins
  output reg chip_select_n_q,
  output reg token_select_n_q,
  output reg read_write_n_q,
  output reg output_enable_n_q,
  output reg high_lane_select_n_q,
  output reg low_lane_select_n_q,
  output reg [`DPM_AW-1:0] addr_q,
  output reg [`DPM_DW-1:0] data_o_q,
  output reg data_oe_q,
  input wire [`DPM_DW-1:0] data_i,
  input wire interrupt_n,
  input wire collision_n,
  // role strap pin
  output reg role_lead_q
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_ACTIVE = 3'h2;
  localparam [2:0] ST_END = 3'h3;

  localparam integer SEL_CYC = `DPM_CEIL_CYC(`DPM_SELECT_TO_DATA_NS);
  localparam integer OE_CYC = `DPM_CEIL_CYC(`DPM_OE_TO_DATA_NS);
  localparam integer FLOW_CYC = `DPM_CEIL_CYC(`DPM_FLOW_THROUGH_NS);
  localparam integer ACC_CYC = (SEL_CYC > OE_CYC) ? SEL_CYC : OE_CYC;
  localparam integer WAIT_CYC = (ACC_CYC > FLOW_CYC) ? ACC_CYC : FLOW_CYC;
  localparam integer RD_INT = WAIT_CYC + `DPM_SYNC_CYC;
  localparam integer WR_INT = `DPM_CEIL_CYC(`DPM_WRITE_PULSE_NS);
  localparam integer TOK_INT = `DPM_CEIL_CYC(`DPM_TOKEN_RECOVER_NS);
  // waits are short, so the low byte is the whole count
  localparam [7:0] RD_CYC = RD_INT[7:0];
  localparam [7:0] WR_CYC = WR_INT[7:0];
  localparam [7:0] TOK_CYC = TOK_INT[7:0];
  localparam [7:0] ONE_CYC = 8'h01;

  localparam [`DPM_AW-1:0] MBX_OWN =
    (RIGHT_PORT != 0) ? `DPM_MBX_RIGHT : `DPM_MBX_LEFT;

  reg [2:0] state_q;
  reg [7:0] cnt_q;
  reg [7:0] busy_wait_q;
  reg write_q;
  reg token_q;
  wire [`DPM_DW-1:0] data_s;
  wire int_s;
  wire busy_s;
  wire busy_hold;
  wire busy_expired;
  wire finish;

  // all pin inputs are asynchronous to clk
  dpm_sync #(.W(`DPM_DW), .INIT({`DPM_DW{1'b0}})) u_sync_data (
    .clk(clk),
    .rst(rst),
    .d(data_i),
    .q(data_s)
  );

  dpm_sync #(.W(1), .INIT(1'b1)) u_sync_int (
    .clk(clk),
    .rst(rst),
    .d(interrupt_n),
    .q(int_s)
  );

  dpm_sync #(.W(1), .INIT(1'b1)) u_sync_busy (
    .clk(clk),
    .rst(rst),
    .d(collision_n),
    .q(busy_s)
  );

  // token accesses ignore the collision flag; memory accesses stretch
  assign busy_hold = !busy_s && !token_q;
  assign busy_expired = busy_hold &&
    (busy_wait_q == `DPM_BUSY_TIMEOUT_CYC);
  assign finish = busy_expired || (!busy_hold && (cnt_q == ONE_CYC));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      busy_wait_q <= 8'h00;
      write_q <= 1'b0;
      token_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_rdata_q <= {`DPM_DW{1'b0}};
      resp_collided_q <= 1'b0;
      mail_pending_q <= 1'b0;
      busy_now_q <= 1'b0;
      chip_select_n_q <= 1'b1;
      token_select_n_q <= 1'b1;
      read_write_n_q <= 1'b1;
      output_enable_n_q <= 1'b1;
      high_lane_select_n_q <= 1'b1;
      low_lane_select_n_q <= 1'b1;
      addr_q <= {`DPM_AW{1'b0}};
      data_o_q <= {`DPM_DW{1'b0}};
      data_oe_q <= 1'b0;
      role_lead_q <= 1'b0;
    end else begin
      // strap is held in lead role so the collision flags are outputs
      role_lead_q <= `DPM_ROLE_LEAD;
      mail_pending_q <= !int_s;
      busy_now_q <= !busy_s;
      resp_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (cmd_valid && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            write_q <= cmd_op[0];
            token_q <= cmd_op[1];
            data_o_q <= cmd_wdata;
            data_oe_q <= cmd_op[0];
            if (cmd_op[1]) begin
              // token latch addressed by low bits, lanes kept off
              addr_q <= {{(`DPM_AW-`DPM_TOK_AW){1'b0}},
                cmd_addr[`DPM_TOK_AW-1:0]};
              high_lane_select_n_q <= 1'b1;
              low_lane_select_n_q <= 1'b1;
            end else begin
              addr_q <= cmd_addr;
              high_lane_select_n_q <= !cmd_lanes[1];
              low_lane_select_n_q <= !cmd_lanes[0];
            end
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // address and data settle one cycle before any strobe
          if (token_q) begin
            token_select_n_q <= 1'b0;
          end else begin
            chip_select_n_q <= 1'b0;
          end
          read_write_n_q <= !write_q;
          output_enable_n_q <= write_q;
          cnt_q <= write_q ? WR_CYC : RD_CYC;
          busy_wait_q <= 8'h00;
          state_q <= ST_ACTIVE;
        end
        ST_ACTIVE: begin
          // a lost arbitration holds the strobes until the flag lifts or the busy wait reaches the timeout
          if (busy_hold) begin
            busy_wait_q <= busy_wait_q + ONE_CYC;
          end else begin
            cnt_q <= cnt_q - ONE_CYC;
          end
          if (finish) begin
            // sampled data is two cycles old, hence the longer read wait
            resp_rdata_q <= data_s;
            // an expired wait means the access may not have happened
            resp_collided_q <= busy_expired;
            // rising strobe edge ends a write; data stays driven
            chip_select_n_q <= 1'b1;
            token_select_n_q <= 1'b1;
            read_write_n_q <= 1'b1;
            output_enable_n_q <= 1'b1;
            cnt_q <= (token_q && write_q) ? TOK_CYC : ONE_CYC;
            state_q <= ST_END;
          end
        end
        ST_END: begin
          // hold data past the rising edge; token write needs recovery
          cnt_q <= cnt_q - ONE_CYC;
          if (cnt_q == ONE_CYC) begin
            data_oe_q <= 1'b0;
            high_lane_select_n_q <= 1'b1;
            low_lane_select_n_q <= 1'b1;
            resp_valid_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // own mailbox address, kept unused and not brought out to users; reading it clears the own flag
  wire [`DPM_AW-1:0] mbx_own_unused = MBX_OWN;

endmodule

/* sim/dpm_host_chk.sv */
// pin and answer assertions for the host port controller
`timescale 1ns/10ps
`include "dpm_defines.vh"
module dpm_host_chk (
  // clock, reset and user side
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire cmd_ready_q,
  input wire [1:0] cmd_op,
  input wire resp_valid_q,
  input wire mail_pending_q,
  input wire role_lead_q,
  // memory port pins
  input wire chip_select_n_q,
  input wire token_select_n_q,
  input wire read_write_n_q,
  input wire output_enable_n_q,
  input wire [`DPM_DW-1:0] data_o_q,
  input wire data_oe_q,
  input wire interrupt_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire take = cmd_valid && cmd_ready_q;
  wire wr = (!chip_select_n_q || !token_select_n_q) && !read_write_n_q;
  property p_sel; !(!chip_select_n_q && !token_select_n_q); endproperty
  a_sel: assert property (p_sel) else $error("two selects low");
  property p_oe; !output_enable_n_q |-> !data_oe_q; endproperty
  a_oe: assert property (p_oe) else $error("bus fight");
  // data must outlast the rising edge that ends the write
  property p_wr; wr |=> data_oe_q && $stable(data_o_q); endproperty
  a_wr: assert property (p_wr) else $error("data not held");
  property p_idle; resp_valid_q |-> chip_select_n_q && token_select_n_q;
  endproperty
  a_idle: assert property (p_idle) else $error("still selected");
  property p_twr; take && cmd_op == `DPM_OP_TOK_WR |-> ##4 resp_valid_q;
  endproperty
  a_twr: assert property (p_twr) else $error("token write late");
  property p_trd; take && cmd_op == `DPM_OP_TOK_RD |-> ##6 resp_valid_q;
  endproperty
  a_trd: assert property (p_trd) else $error("token read late");
  property p_mail; $fell(interrupt_n) |-> ##[1:4] mail_pending_q; endproperty
  a_mail: assert property (p_mail) else $error("flag not seen");
  property p_role; !$past(rst) |-> role_lead_q; endproperty
  a_role: assert property (p_role) else $error("not lead");
endmodule

bind dpm_host dpm_host_chk i_dpm_host_chk (.*);

/* sim/dpm_dev_model.sv */
// behavioural model of the left port of the dual-port memory
`timescale 1ns/10ps
`include "dpm_defines.vh"
module dpm_dev_model (
  // host port pins
  input wire chip_select_n_q,
  input wire token_select_n_q,
  input wire read_write_n_q,
  input wire output_enable_n_q,
  input wire high_lane_select_n_q,
  input wire low_lane_select_n_q,
  input wire [`DPM_AW-1:0] addr_q,
  input wire [`DPM_DW-1:0] data_o_q,
  input wire data_oe_q,
  output wire [`DPM_DW-1:0] data_i,
  // flags and far port
  input wire collision_n,
  input wire far_mail,
  output reg interrupt_n = 1'h1
);
  reg [`DPM_DW-1:0] mem [0:16383];
  reg [7:0] own_q = 8'h00;
  integer i;
  wire rd = read_write_n_q && !output_enable_n_q;
  wire tok = !token_select_n_q && rd;
  wire [`DPM_DW-1:0] v = tok ? {18{~own_q[addr_q[2:0]]}} : mem[addr_q];
  wire [`DPM_DW-1:0] m = tok ? 18'h3FFFF :
    {{9{~high_lane_select_n_q}}, {9{~low_lane_select_n_q}}};
  // an idle bus shows the inverse so stale data never passes
  assign #(`DPM_SELECT_TO_DATA_NS) data_i =
    (tok || rd && !chip_select_n_q) ? v ^ ~m : ~v;
  always @(posedge (chip_select_n_q | read_write_n_q))
    for (i = 0; i < 18; i = i + 1)
      if (data_oe_q && !(i > 8 ? high_lane_select_n_q : low_lane_select_n_q))
        mem[addr_q][i] = data_o_q[i];
  always @(posedge (token_select_n_q | read_write_n_q))
    if (data_oe_q)
      own_q[addr_q[2:0]] = ~data_o_q[0];
  always @(posedge far_mail)
    interrupt_n = 1'h0;
  // a colliding port cannot clear its own flag
  always @(posedge chip_select_n_q)
    if (read_write_n_q && addr_q == `DPM_MBX_LEFT && collision_n)
      interrupt_n = 1'h1;
endmodule

/* sim/dpm_host_test.sv */
// self-checking bench for the host port controller
`timescale 1ns/10ps
`include "dpm_defines.vh"
module dpm_host_test;
  reg clk = 1'h0, rst = 1'h1, cmd_valid = 1'h0;
  reg collision_n = 1'h1, far_mail = 1'h0;
  reg [1:0] cmd_op = 2'h0, cmd_lanes = 2'h0;
  reg [`DPM_AW-1:0] cmd_addr = 14'h0000;
  reg [`DPM_DW-1:0] cmd_wdata = 18'h00000;
  wire cmd_ready_q, resp_valid_q, resp_collided_q, mail_pending_q;
  wire busy_now_q, chip_select_n_q, token_select_n_q, read_write_n_q;
  wire output_enable_n_q, high_lane_select_n_q, low_lane_select_n_q;
  wire data_oe_q, interrupt_n, role_lead_q;
  wire [`DPM_AW-1:0] addr_q;
  wire [`DPM_DW-1:0] resp_rdata_q, data_o_q, data_i;
  integer err_count = 0, check_count = 0, n;
  dpm_host i_dpm_host (.*);
  dpm_dev_model i_dpm_dev_model (.*);
  always #25 clk = ~clk;
  task chk(input [17:0] seen, input [17:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // n ends as cycles from take to answer, capped so a hang shows
  task cmd(input [1:0] op, input [13:0] a, input [17:0] d, input [1:0] l);
    begin
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_lanes = l;
      cmd_valid = 1'h1;
      @(posedge clk);
      while (!cmd_ready_q) @(posedge clk);
      #1 cmd_valid = 1'h0;
      n = 0;
      while (!resp_valid_q && n < 100) begin
        @(posedge clk);
        #1 n = n + 1;
      end
    end
  endtask
  task t_mem;
    begin
      cmd(`DPM_OP_MEM_WR, 14'h2D23, 18'h2B4C7, 2'h3);
      chk(n[17:0], 18'h00003);
      cmd(`DPM_OP_MEM_RD, 14'h2D23, 18'h00000, 2'h3);
      chk(n[17:0], 18'h00005);
      chk(resp_rdata_q, 18'h2B4C7);
      cmd(`DPM_OP_MEM_WR, 14'h2D23, 18'h00000, 2'h1);
      cmd(`DPM_OP_MEM_WR, 14'h2D23, 18'h3FFFF, 2'h0);
      cmd(`DPM_OP_MEM_RD, 14'h2D23, 18'h00000, 2'h3);
      chk(resp_rdata_q, 18'h2B400);
      $display("memory test done");
    end
  endtask
  task t_mail;
    begin
      cmd(`DPM_OP_MEM_WR, `DPM_MBX_LEFT, 18'h1A5A5, 2'h3);
      far_mail = 1'h1;
      repeat (5) @(posedge clk);
      #1 chk(mail_pending_q, 18'h00001);
      cmd(`DPM_OP_MEM_RD, `DPM_MBX_RIGHT, 18'h00000, 2'h3);
      chk(mail_pending_q, 18'h00001);
      collision_n = 1'h0;
      cmd(`DPM_OP_MEM_RD, `DPM_MBX_LEFT, 18'h00000, 2'h3);
      chk(resp_collided_q, 18'h00001);
      chk(busy_now_q, 18'h00001);
      chk(mail_pending_q, 18'h00001);
      chk(n[17:0], 18'h00043);
      collision_n = 1'h1;
      cmd(`DPM_OP_MEM_RD, `DPM_MBX_LEFT, 18'h00000, 2'h3);
      repeat (4) @(posedge clk);
      #1 chk(mail_pending_q, 18'h00000);
      chk(resp_rdata_q, 18'h1A5A5);
      chk(resp_collided_q, 18'h00000);
      far_mail = 1'h0;
      $display("mailbox test done");
    end
  endtask
  task t_tok;
    begin
      cmd(`DPM_OP_TOK_WR, 14'h0005, 18'h00000, 2'h0);
      chk(n[17:0], 18'h00003);
      cmd(`DPM_OP_TOK_RD, 14'h0005, 18'h00000, 2'h0);
      chk(n[17:0], 18'h00005);
      chk(resp_rdata_q, 18'h00000);
      cmd(`DPM_OP_TOK_WR, 14'h0005, 18'h3FFFF, 2'h0);
      cmd(`DPM_OP_TOK_RD, 14'h0005, 18'h00000, 2'h0);
      chk(resp_rdata_q, 18'h3FFFF);
      $display("token test done");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'h0;
    t_mem;
    t_mail;
    t_tok;
    stop_test;
  end
  // whole run needs some 160 cycles; this allows far more
  initial begin
    #200000;
    err_count = err_count + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule
